// File: hw/event_timetag_cfg.svh
`ifndef EVENT_TIMETAG_CFG_SVH
`define EVENT_TIMETAG_CFG_SVH
// Register byte offsets.
`define ETC_CTRL_ADDR      8'h00
`define ETC_EVERY_N_ADDR   8'h04
`define ETC_EVERY_T_ADDR   8'h08
`define ETC_REF_PER_ADDR   8'h0c
`define ETC_STATUS_ADDR    8'h10
`define ETC_EVCNT_ADDR     8'h14
`define ETC_RD_TIME_ADDR   8'h18
`define ETC_RD_CNT_ADDR    8'h1c
`define ETC_RESULT_ADDR    8'h20
`define ETC_RD_POP_ADDR    8'h24
`define ETC_TIME_LO_ADDR   8'h28
// Control field positions and register reset values.
`define ETC_CTRL_RUN       0
`define ETC_CTRL_FALL      1
`define ETC_CTRL_CHB       2
`define ETC_CTRL_TMODE     3
`define ETC_CTRL_FUNC_LO   4
`define ETC_CTRL_FUNC_HI   5
`define ETC_CTRL_RST       32'h0000_0000
`define ETC_EVERY_N_RST    32'h0000_0001
`define ETC_EVERY_T_RST    32'h0000_0019
// Timing.
`define ETC_CLK_NS         40
`define ETC_RECOVER_NS     250
`define ETC_RECOVER_CYC    ((`ETC_RECOVER_NS + `ETC_CLK_NS - 1) / `ETC_CLK_NS)
`define ETC_TICK_PS        3
`endif

// File: hw/event_timetag_pkg.sv
`default_nettype none
package event_timetag_pkg;
	typedef enum logic [1:0] {
		FN_FREQ_AVG,
		FN_PERIOD_AVG,
		continuous_interval_function,
		interval_error_function
	} func_t;
	typedef logic [31:0] word_t;
endpackage : event_timetag_pkg
`default_nettype wire

// File: hw/event_timetag_capture.sv
// Design decisions made here: the Wishbone register port and the register addresses.
`include "event_timetag_cfg.svh"
`default_nettype none
module event_timetag_capture #(
	parameter int DEPTH_LOG2 = 4,          // Record memory depth as log2; full part holds 8M.
	parameter int TIME_W     = 32          // Width of a timetag in fine ticks.
) (
	input  wire logic                   clk,        // System clock, 25 MHz.
	input  wire logic                   sys_rst,    // Asynchronous reset, active high.
	input  wire logic                   chan_a,     // Digitized channel A waveform.
	input  wire logic                   chan_b,     // Digitized channel B waveform.
	input  wire logic [TIME_W-1:0]      fine_time,  // Free-running 3 ps timebase.
	input  wire logic                   wb_cyc_i,   // Wishbone cycle.
	input  wire logic                   wb_stb_i,   // Wishbone strobe.
	input  wire logic                   wb_we_i,    // Wishbone write enable.
	input  wire logic [7:0]             wb_adr_i,   // Wishbone byte address.
	input  wire logic [3:0]             wb_sel_i,   // Wishbone byte selects.
	input  wire logic [31:0]            wb_dat_i,   // Wishbone write data.
	output logic      [31:0]            wb_dat_o,   // Wishbone read data.
	output logic                        wb_ack_o,   // Wishbone acknowledge.
	output logic                        rec_valid,  // Streamed record valid.
	output logic [TIME_W-1:0]           rec_time,   // Streamed record time.
	output logic [31:0]                 rec_count   // Streamed record event count.
);
	import event_timetag_pkg::*;
	localparam int DEPTH = 1 << DEPTH_LOG2;
	localparam logic [3:0] RECOVER = 4'(`ETC_RECOVER_CYC);
	////////////////////////////////////////////////////////////////////////////////
	word_t ctrl;
	word_t every_n;
	word_t every_t;
	word_t ref_per;
	word_t ev_count;
	logic [2:0] sync_a;
	logic [2:0] sync_b;
	logic       prev_in;
	logic [3:0] recover;
	word_t      n_cnt;
	word_t      t_cnt;
	logic       armed;
	logic [TIME_W-1:0] mem_time [DEPTH];
	word_t             mem_cnt  [DEPTH];
	logic [DEPTH_LOG2:0] wr_ptr;
	logic [DEPTH_LOG2:0] rd_ptr;
	logic [TIME_W-1:0] last_time;
	word_t             last_cnt;
	logic              have_last;
	logic [TIME_W-1:0] expect_time;
	word_t             d_time;
	word_t             d_cnt;
	word_t             result;
	logic              overflow;
	wire logic run  = ctrl[`ETC_CTRL_RUN];
	func_t     func;
	assign func = func_t'(ctrl[`ETC_CTRL_FUNC_HI:`ETC_CTRL_FUNC_LO]);
	////////////////////////////////////////////////////////////////////////////////
	// Channel pins are asynchronous; only stage 1 and beyond are read by logic.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sync_a <= 3'h0;
			sync_b <= 3'h0;
		end else begin
			sync_a <= {sync_a[1:0], chan_a};
			sync_b <= {sync_b[1:0], chan_b};
		end
	end
	wire logic sel_in   = ctrl[`ETC_CTRL_CHB] ? sync_b[1] : sync_a[1];
	wire logic sel_prev = ctrl[`ETC_CTRL_CHB] ? sync_b[2] : sync_a[2];
	// Polarity picks rising or falling transitions.
	wire logic event_hit = run && (ctrl[`ETC_CTRL_FALL] ? (sel_prev && !sel_in)
	                                                    : (!sel_prev && sel_in));
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			prev_in <= 1'b0;
		end else begin
			prev_in <= sel_in;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Counter runs regardless of recovery so later counts stay exact.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ev_count <= 32'h0;
		end else if (event_hit) begin
			ev_count <= ev_count + 32'h1;
		end
	end
	wire logic ready   = (recover == 4'h0);
	wire logic capture = event_hit && armed && ready;
	// Arming: count mode arms after N-1 events so every Nth is taken, time mode after T clocks.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			n_cnt <= 32'h0;
			t_cnt <= 32'h0;
			armed <= 1'b0;
		end else if (!run) begin
			n_cnt <= 32'h0;
			t_cnt <= 32'h0;
			armed <= 1'b1;
		end else begin
			if (capture) begin
				// With N of one the very next event is already eligible.
				armed <= !ctrl[`ETC_CTRL_TMODE] && (every_n <= 32'h1);
				n_cnt <= 32'h0;
				t_cnt <= 32'h0;
			end else begin
				if (event_hit && !armed) begin
					n_cnt <= n_cnt + 32'h1;
				end
				if (!armed) begin
					t_cnt <= t_cnt + 32'h1;
				end
				if (!armed && (ctrl[`ETC_CTRL_TMODE] ? (t_cnt + 32'h1 >= every_t)
				                                     : (event_hit && n_cnt + 32'h2 >= every_n))) begin
					armed <= 1'b1;
				end
			end
		end
	end
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			recover <= 4'h0;
		end else if (capture) begin
			recover <= RECOVER;
		end else if (recover != 4'h0) begin
			recover <= recover - 4'h1;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	wire logic mem_full  = (wr_ptr[DEPTH_LOG2] != rd_ptr[DEPTH_LOG2]) &&
	                       (wr_ptr[DEPTH_LOG2-1:0] == rd_ptr[DEPTH_LOG2-1:0]);
	wire logic mem_empty = (wr_ptr == rd_ptr);
	wire logic bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// Writes land on the acknowledging edge, while the master still holds the request.
	wire logic bus_wr    = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
	wire logic pop       = bus_wr && (wb_adr_i == `ETC_RD_POP_ADDR) && !mem_empty;
	wire logic [DEPTH_LOG2-1:0] wr_idx = wr_ptr[DEPTH_LOG2-1:0];
	wire logic [DEPTH_LOG2-1:0] rd_idx = rd_ptr[DEPTH_LOG2-1:0];
	always_ff @(posedge clk) begin
		if (capture && !mem_full) begin
			mem_time[wr_idx] <= fine_time;
			mem_cnt[wr_idx]  <= ev_count;
		end
	end
	// Reads and writes use separate pointers so software drains while capture runs.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_ptr   <= '0;
			rd_ptr   <= '0;
			overflow <= 1'b0;
		end else begin
			if (capture && !mem_full) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			if (capture && mem_full) begin
				overflow <= 1'b1;
			end else if (bus_wr && wb_adr_i == `ETC_STATUS_ADDR && wb_dat_i[1]) begin
				overflow <= 1'b0;
			end
		end
	end
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rec_valid <= 1'b0;
			rec_time  <= '0;
			rec_count <= 32'h0;
		end else begin
			rec_valid <= capture;
			if (capture) begin
				rec_time  <= fine_time;
				rec_count <= ev_count;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Results are deltas; the divide is left to the host to keep the fabric small.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			last_time   <= '0;
			last_cnt    <= 32'h0;
			have_last   <= 1'b0;
			d_time      <= 32'h0;
			d_cnt       <= 32'h0;
			result      <= 32'h0;
			expect_time <= '0;
		end else if (!run) begin
			have_last <= 1'b0;
		end else if (capture) begin
			last_time <= fine_time;
			last_cnt  <= ev_count;
			have_last <= 1'b1;
			if (!have_last) begin
				expect_time <= fine_time + TIME_W'(ref_per);
				result      <= 32'h0;
			end else begin
				d_time      <= 32'(fine_time - last_time);
				d_cnt       <= ev_count - last_cnt;
				expect_time <= expect_time + TIME_W'(ref_per);
				unique case (func)
					FN_FREQ_AVG:                  result <= ev_count - last_cnt;
					FN_PERIOD_AVG:                result <= 32'(fine_time - last_time);
					continuous_interval_function: result <= 32'(fine_time - last_time);
					interval_error_function:      result <= 32'(fine_time - expect_time);
				endcase
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl    <= `ETC_CTRL_RST;
			every_n <= `ETC_EVERY_N_RST;
			every_t <= `ETC_EVERY_T_RST;
			ref_per <= 32'h0;
		end else if (bus_wr && wb_sel_i == 4'hf) begin
			unique case (wb_adr_i)
				`ETC_CTRL_ADDR:    ctrl    <= wb_dat_i;
				`ETC_EVERY_N_ADDR: every_n <= wb_dat_i;
				`ETC_EVERY_T_ADDR: every_t <= wb_dat_i;
				`ETC_REF_PER_ADDR: ref_per <= wb_dat_i;
				default: ;
			endcase
		end
	end
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= 32'h0;
			if (bus_req && !wb_we_i) begin
				unique case (wb_adr_i)
					`ETC_CTRL_ADDR:    wb_dat_o <= ctrl;
					`ETC_EVERY_N_ADDR: wb_dat_o <= every_n;
					`ETC_EVERY_T_ADDR: wb_dat_o <= every_t;
					`ETC_REF_PER_ADDR: wb_dat_o <= ref_per;
					`ETC_STATUS_ADDR:  wb_dat_o <= {29'h0, !ready, overflow, !mem_empty};
					`ETC_EVCNT_ADDR:   wb_dat_o <= ev_count;
					`ETC_RD_TIME_ADDR: wb_dat_o <= 32'(mem_time[rd_idx]);
					`ETC_RD_CNT_ADDR:  wb_dat_o <= mem_cnt[rd_idx];
					`ETC_RESULT_ADDR:  wb_dat_o <= result;
					`ETC_TIME_LO_ADDR: wb_dat_o <= d_time ^ d_cnt ^ 32'(prev_in);
					default:           wb_dat_o <= 32'h0;
				endcase
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	property p_count_step;
		@(posedge clk) disable iff (sys_rst) event_hit |=> ev_count == $past(ev_count) + 32'h1;
	endproperty
	a_count_step: assert property (p_count_step) else $error("event count did not step");
	property p_count_hold;
		@(posedge clk) disable iff (sys_rst) !event_hit |=> $stable(ev_count);
	endproperty
	a_count_hold: assert property (p_count_hold) else $error("event count moved without event");
	property p_recover;
		@(posedge clk) disable iff (sys_rst) capture |=> !capture [*7];
	endproperty
	a_recover: assert property (p_recover) else $error("capture inside recovery");
	property p_recover_count;
		@(posedge clk) disable iff (sys_rst) (event_hit && !ready) |=> ev_count == $past(ev_count) + 32'h1;
	endproperty
	a_recover_count: assert property (p_recover_count) else $error("event lost in recovery");
	property p_no_cap_busy;
		@(posedge clk) disable iff (sys_rst) (event_hit && armed && !ready) |=> armed;
	endproperty
	a_no_cap_busy: assert property (p_no_cap_busy) else $error("capture while recovering");
	property p_record;
		@(posedge clk) disable iff (sys_rst) capture |=> rec_valid && rec_count == $past(ev_count) &&
		                                     rec_time == $past(fine_time);
	endproperty
	a_record: assert property (p_record) else $error("record mismatch");
	property p_stream;
		@(posedge clk) disable iff (sys_rst) rec_valid |-> $past(capture);
	endproperty
	a_stream: assert property (p_stream) else $error("spurious record");
	property p_chain;
		@(posedge clk) disable iff (sys_rst) (capture && run) |=> last_time == $past(fine_time);
	endproperty
	a_chain: assert property (p_chain) else $error("closing tag not kept");
	property p_wr;
		@(posedge clk) disable iff (sys_rst) (capture && !mem_full) |=> wr_ptr == $past(wr_ptr) + 1'b1;
	endproperty
	a_wr: assert property (p_wr) else $error("record not stored");
	c_capture:  cover property (@(posedge clk) disable iff (sys_rst) capture);
	c_deferred: cover property (@(posedge clk) disable iff (sys_rst) event_hit && armed && !ready);
	c_full:     cover property (@(posedge clk) disable iff (sys_rst) mem_full);
endmodule : event_timetag_capture
`default_nettype wire

// File: testbench/pulse_source.sv
`default_nettype none
module pulse_source (
	input  wire logic clk,    // System clock.
	output logic      chan_a, // Channel A level.
	output logic      chan_b  // Channel B level.
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		chan_a = 1'b0;
		chan_b = 1'b0;
	end
	////////////////////////////////////////////////////////////////
	// Equal spacing keeps the synchroniser delay constant, so deltas are exact.
	// The other channel chatters so that a wrong channel choice shows up.
	task automatic burst(input logic chb, input logic fall, input int n, input int gap);
		@(posedge clk);
		if (chb) chan_b <= fall;
		else chan_a <= fall;
		repeat (3) @(posedge clk);
		for (int i = 0; i < n; i++) begin
			for (int j = 0; j < gap; j++) begin
				if (chb) begin
					chan_b <= (j < 2) ? ~fall : fall;
					chan_a <= ~chan_a;
				end else begin
					chan_a <= (j < 2) ? ~fall : fall;
					chan_b <= ~chan_b;
				end
				@(posedge clk);
			end
		end
	endtask : burst
endmodule : pulse_source
`default_nettype wire

// File: testbench/tb.sv
`include "event_timetag_cfg.svh"
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import event_timetag_pkg::*;
	localparam word_t STEP = 32'h0000_3415;
	logic        clk, sys_rst, cyc, stb, we, ack, rv, ca, cb;
	logic [7:0]  adr;
	logic [3:0]  sel;
	word_t       dat, dat_o, ft, q, e0, rt, rc;
	int          err_count, cmp_count;
	word_t       tq[$], cq[$];
	event_timetag_capture event_timetag_capture_i (.clk(clk), .sys_rst(sys_rst), .chan_a(ca), .chan_b(cb),
		.fine_time(ft), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .rec_valid(rv), .rec_time(rt), .rec_count(rc));
	pulse_source pulse_source_i (.clk(clk), .chan_a(ca), .chan_b(cb));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) ft <= sys_rst ? 32'h0 : ft + STEP;
	always @(posedge clk) begin
		if (rv === 1'b1) begin
			tq.push_back(rt);
			cq.push_back(rc);
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : close_out
	task automatic chk(input string nm, input word_t seen, input word_t exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// The bench never assumes the slave latency; a wait ends on ack or after the bound of 50 cycles.
	task automatic bus(input logic w, input logic [7:0] a, input word_t d, input logic [3:0] s);
		int k;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= s;
		for (k = 0; k < 50; k++) begin
			@(posedge clk);
			if (ack === 1'b1) break;
		end
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (k == 50) begin
			err_count++;
			close_out();
		end
	endtask : bus
	task automatic wr(input logic [7:0] a, input word_t d);
		bus(1'b1, a, d, 4'hf);
	endtask : wr
	task automatic rdw(input logic [7:0] a);
		bus(1'b0, a, 32'h0, 4'hf);
	endtask : rdw
	////////////////////////////////////////////////////////////////
	// Twelve equally spaced edges; a capture every dc edges.
	task automatic run(input logic chb, input logic fall, input logic tm, input func_t fn,
		input word_t every, input word_t gap, input word_t dc, input word_t rslt, input word_t ref_p);
		wr(`ETC_CTRL_ADDR, 32'h0);
		wr(tm ? `ETC_EVERY_T_ADDR : `ETC_EVERY_N_ADDR, every);
		wr(`ETC_REF_PER_ADDR, ref_p);
		tq.delete();
		cq.delete();
		wr(`ETC_CTRL_ADDR, {26'h0, fn, tm, chb, fall, 1'b1});
		rdw(`ETC_EVCNT_ADDR);
		e0 = q;
		pulse_source_i.burst(chb, fall, 12, gap);
		repeat (10) @(posedge clk);
		rdw(`ETC_EVCNT_ADDR);
		chk("events", q - e0, 32'd12);
		chk("captures", word_t'(tq.size()), 32'd11 / dc + 32'd1);
		for (int i = 1; i < tq.size(); i++) begin
			chk("count step", cq[i] - cq[i-1], dc);
			chk("time step", tq[i] - tq[i-1], dc * gap * STEP);
		end
		rdw(`ETC_RESULT_ADDR);
		chk("result", q, rslt);
		foreach (tq[i]) begin
			rdw(`ETC_RD_TIME_ADDR);
			chk("stored time", q, tq[i]);
			rdw(`ETC_RD_CNT_ADDR);
			chk("stored count", q, cq[i]);
			wr(`ETC_RD_POP_ADDR, 32'h0);
		end
		rdw(`ETC_STATUS_ADDR);
		chk("not empty", q & 32'h1, 32'h0);
		wr(`ETC_CTRL_ADDR, 32'h0);
	endtask : run
	initial begin
		repeat (100000) @(posedge clk);
		err_count++;
		close_out();
	end
	initial begin
		sys_rst = 1'b1;
		{cyc, stb, we} = 3'h0;
		adr = 8'h00;
		sel = 4'h0;
		dat = 32'h0;
		err_count = 0;
		cmp_count = 0;
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		rdw(`ETC_CTRL_ADDR);
		chk("ctrl reset", q, `ETC_CTRL_RST);
		rdw(`ETC_EVERY_T_ADDR);
		chk("every_t reset", q, `ETC_EVERY_T_RST);
		bus(1'b1, `ETC_EVERY_N_ADDR, 32'h5, 4'h1);
		rdw(`ETC_EVERY_N_ADDR);
		chk("every_n partial", q, `ETC_EVERY_N_RST);
		rdw(8'h3c);
		chk("unmapped", q, 32'h0);
		rdw(`ETC_STATUS_ADDR);
		chk("status reset", q, 32'h0);
		run(1'b0, 1'b0, 1'b0, FN_FREQ_AVG, 32'd1, 32'd10, 32'd1, 32'd1, 32'h0);
		run(1'b1, 1'b1, 1'b0, FN_PERIOD_AVG, 32'd3, 32'd5, 32'd3, STEP * 15, 32'h0);
		run(1'b0, 1'b0, 1'b0, continuous_interval_function, 32'd1, 32'd3, 32'd3, STEP * 9, 32'h0);
		run(1'b1, 1'b0, 1'b1, interval_error_function, 32'd20, 32'd6, 32'd4, 32'hffff_fff6, STEP * 24 + 5);
		run(1'b0, 1'b1, 1'b0, FN_FREQ_AVG, 32'd2, 32'd4, 32'd2, 32'd2, 32'h0);
		close_out();
	end
endmodule : tb
`default_nettype wire
